//--- hw/fhs_pkg.sv
// Purpose: constants for the floppy host status and control register bank
// Assumes: 8-bit host data bus, primary i/o addresses
// Notes: status-A and status-B share one layout mode input
//
// Functional notes
// - status-A bit 0 shows head direction inverted, 1 means outward.
// - status-A bit 3 shows head side inverted, 1 means side 0.
// - status-A bit 5 latches step going active, clears on input-reg read/reset.
// - status-A bits 6 and 7 mirror dma request and floppy interrupt.
// - basic at mode floats status-B reads; enhanced mode always readable.
// - enhanced status-B bits 1:0 show motors; hard reset clears only.
// - enhanced status-B bit 2 write gate; bits 3,4 toggle on data falls.
// - enhanced status-B bit 5 drive select bit 0; bits 7:6 read one.
// - alternate status-B bits 0, 1 and 7 always read one.
// - alternate status-B bit 2 latches write gate rise, clears on read.
// - alternate bits 3,4 latch data falls, clear on read; no gating.
// - alternate status-B bits 5,6 show drive selects active low.
// - output control writable anytime; hard reset zeroes it, soft keeps it.
// - output control bits 1:0 encode one selected drive.
// - bit 2 low holds soft reset until written high; other bits kept.
// - at/alternate modes: bit 3 low floats request/irq, ignores ack and tc.
// - enhanced mode keeps dma and irq pins enabled whatever bit 3; bit 2 still resets.
// - bits 5:4 drive motors; bits 7:6 read zero.
// - tape register bits 1:0 hold tape drive number; drive 0 never.
// - tape register bits 7:2 float on read; kept over soft reset.
// - drive select asserts only with matching motor bit; motors inverted.
// - basic at mode floats status-A reads.
package fhs_pkg;
	localparam logic [9:0] FHS_ADDR_STAT_A = 10'h3F0;
	localparam logic [9:0] FHS_ADDR_STAT_B = 10'h3F1;
	localparam logic [9:0] FHS_ADDR_DOC = 10'h3F2;
	localparam logic [9:0] FHS_ADDR_TAPE = 10'h3F3;
	localparam logic [9:0] FHS_ADDR_DIN = 10'h3F7;
	localparam logic [7:0] FHS_DOC_RST = 8'h00;
	localparam logic [1:0] FHS_TAPE_RST = 2'h0;
	localparam int FHS_DOC_SRST_BIT = 2;
	localparam int FHS_DOC_DMA_IRQ_ENABLE_BIT = 3;
	localparam int FHS_DOC_MOT0_BIT = 4;
	localparam int FHS_DOC_MOT1_BIT = 5;
	localparam logic [1:0] FHS_DRV0 = 2'h0;
	localparam logic [1:0] FHS_DRV1 = 2'h1;
	// 100 ns least soft reset width at 4 ns clock
	localparam int FHS_SRST_MIN_NS = 100;
	localparam int FHS_CLK_NS = 4;
	localparam int FHS_SRST_CYC = (FHS_SRST_MIN_NS + FHS_CLK_NS - 1) / FHS_CLK_NS;
	typedef enum logic [1:0] {
		FHS_MODE_AT,
		FHS_MODE_ENH,
		FHS_MODE_ALT
	} fhs_mode_t;
endpackage

//--- hw/fhs_edge_latch.sv
// Purpose: edge detection for one disk line with sticky and toggle views
// Assumes: input synchronous to clk_i
// Notes: set wins over a clear in the same cycle
`timescale 1ns/1ps
module fhs_edge_latch
	import fhs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic soft_rst_i,
	input wire logic line_i,
	input wire logic rise_sel_i,
	input wire logic clear_i,
	output logic sticky_o,
	output logic toggle_o
);
	logic prev_r;
	logic prev_nxt;
	logic sticky_r;
	logic sticky_nxt;
	logic toggle_r;
	logic toggle_nxt;
	logic hit;

	// next state; rise_sel picks the active-going or inactive-going edge
	always_comb begin
		prev_nxt = line_i;
		hit = rise_sel_i ? (line_i & ~prev_r) : (~line_i & prev_r);
		toggle_nxt = toggle_r ^ hit;
		if (hit) begin
			sticky_nxt = 1'b1;
		end else if (clear_i | soft_rst_i) begin
			sticky_nxt = 1'b0;
		end else begin
			sticky_nxt = sticky_r;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prev_r <= 1'b0;
			sticky_r <= 1'b0;
			toggle_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			sticky_r <= sticky_nxt;
			toggle_r <= toggle_nxt;
		end
	end

	assign sticky_o = sticky_r;
	assign toggle_o = toggle_r;
endmodule

//--- hw/fhs_top.sv
// Purpose: host status and control register bank of a floppy controller
// Assumes: isa-style strobes one cycle wide, synchronous to clk_i
// Notes: data bus is split into in, out and output enable
`timescale 1ns/1ps
module fhs_top
	import fhs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] mode_i,
	input wire logic [9:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic [7:0] data_oe_o,
	input wire logic head_dir_in_i,
	input wire logic head_side_select_i,
	input wire logic write_protect_i,
	input wire logic index_pulse_i,
	input wire logic track_zero_i,
	input wire logic step_i,
	input wire logic write_gate_i,
	input wire logic read_data_i,
	input wire logic write_data_i,
	input wire logic dma_req_core_i,
	input wire logic floppy_irq_core_i,
	input wire logic dma_ack_n_i,
	input wire logic term_count_i,
	output logic dma_req_o,
	output logic dma_req_oe_o,
	output logic floppy_irq_o,
	output logic floppy_irq_oe_o,
	output logic dma_ack_n_o,
	output logic term_count_o,
	output logic soft_reset_n_o,
	output logic [1:0] tape_drive_o,
	output logic drive_sel_0_n_o,
	output logic drive_sel_1_n_o,
	output logic motor_on_0_n_o,
	output logic motor_on_1_n_o
);
	////////////////////////////////////////////////////////////////////////
	// register state
	logic [7:0] doc_r;
	logic [7:0] doc_nxt;
	logic [1:0] tape_r;
	logic [1:0] tape_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic [7:0] oe_r;
	logic [7:0] oe_nxt;
	logic srst_hold_r;
	logic srst_hold_nxt;
	logic [$clog2(FHS_SRST_CYC+1)-1:0] srst_cnt_r;
	logic [$clog2(FHS_SRST_CYC+1)-1:0] srst_cnt_nxt;
	fhs_mode_t mode;
	logic din_read;
	logic soft_rst;
	logic pins_en;
	logic step_stk;
	logic wg_stk;
	logic rd_stk;
	logic rd_tog;
	logic wd_stk;
	logic wd_tog;
	logic ds0_n;
	logic ds1_n;
	logic [7:0] stat_a;
	logic [7:0] stat_b;

	// address compare used by every decode
	function automatic logic hit(input logic [9:0] a, input logic [9:0] r);
		hit = (a == r);
	endfunction

	assign mode = fhs_mode_t'(mode_i);
	assign din_read = rd_i & hit(addr_i, FHS_ADDR_DIN);
	assign soft_rst = ~doc_r[FHS_DOC_SRST_BIT] | srst_hold_r;

	////////////////////////////////////////////////////////////////////////
	// edge latches on disk lines; the write-data one ignores write gate
	fhs_edge_latch u_step (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.soft_rst_i(soft_rst),
		.line_i(step_i),
		.rise_sel_i(1'b1),
		.clear_i(din_read),
		.sticky_o(step_stk),
		.toggle_o()
	);
	fhs_edge_latch u_write_gate (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.soft_rst_i(1'b0),
		.line_i(write_gate_i),
		.rise_sel_i(1'b1),
		.clear_i(din_read),
		.sticky_o(wg_stk),
		.toggle_o()
	);
	fhs_edge_latch u_rdata (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.soft_rst_i(1'b0),
		.line_i(read_data_i),
		.rise_sel_i(1'b0),
		.clear_i(din_read),
		.sticky_o(rd_stk),
		.toggle_o(rd_tog)
	);
	fhs_edge_latch u_wdata (
		.clk_i(clk_i),
		.rst_b_i(rst_b_i),
		.soft_rst_i(1'b0),
		.line_i(write_data_i),
		.rise_sel_i(1'b0),
		.clear_i(din_read),
		.sticky_o(wd_stk),
		.toggle_o(wd_tog)
	);

	////////////////////////////////////////////////////////////////////////
	// drive decode: a select only asserts with its own motor bit
	always_comb begin
		ds0_n = ~((doc_r[1:0] == FHS_DRV0) & doc_r[FHS_DOC_MOT0_BIT]);
		ds1_n = ~((doc_r[1:0] == FHS_DRV1) & doc_r[FHS_DOC_MOT1_BIT]);
	end
	assign drive_sel_0_n_o = ds0_n;
	assign drive_sel_1_n_o = ds1_n;
	assign motor_on_0_n_o = ~doc_r[FHS_DOC_MOT0_BIT];
	assign motor_on_1_n_o = ~doc_r[FHS_DOC_MOT1_BIT];
	assign soft_reset_n_o = ~soft_rst;
	assign tape_drive_o = tape_r;

	////////////////////////////////////////////////////////////////////////
	// dma and interrupt pin enables
	always_comb begin
		pins_en = (mode == FHS_MODE_ENH) | doc_r[FHS_DOC_DMA_IRQ_ENABLE_BIT];
	end
	assign dma_req_o = dma_req_core_i;
	assign floppy_irq_o = floppy_irq_core_i;
	assign dma_req_oe_o = pins_en;
	assign floppy_irq_oe_o = pins_en;
	// disabled ack and terminal count inputs are forced inactive
	assign dma_ack_n_o = pins_en ? dma_ack_n_i : 1'b1;
	assign term_count_o = pins_en & term_count_i;

	////////////////////////////////////////////////////////////////////////
	// status views
	always_comb begin
		stat_a = {floppy_irq_core_i, dma_req_core_i, step_stk,
			track_zero_i, ~head_side_select_i, index_pulse_i,
			write_protect_i, ~head_dir_in_i};
		if (mode == FHS_MODE_ENH) begin
			stat_b = {2'b11, doc_r[0], wd_tog, rd_tog,
				write_gate_i, ~motor_on_1_n_o, ~motor_on_0_n_o};
		end else begin
			stat_b = {1'b1, ds1_n, ds0_n, wd_stk, rd_stk,
				wg_stk, 2'b11};
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register writes and soft reset minimum hold
	always_comb begin
		doc_nxt = doc_r;
		tape_nxt = tape_r;
		srst_hold_nxt = srst_hold_r;
		srst_cnt_nxt = srst_cnt_r;
		if (wr_i && hit(addr_i, FHS_ADDR_DOC)) begin
			doc_nxt = {2'b00, data_i[5:0]};
		end
		if (wr_i && hit(addr_i, FHS_ADDR_TAPE)) begin
			tape_nxt = data_i[1:0];
		end
		// stretch a short low pulse so the core sees at least 100 ns
		if (!doc_r[FHS_DOC_SRST_BIT]) begin
			srst_hold_nxt = 1'b1;
			srst_cnt_nxt = '0;
		end else if (srst_hold_r) begin
			if (srst_cnt_r == ($clog2(FHS_SRST_CYC+1))'(FHS_SRST_CYC - 1)) begin
				srst_hold_nxt = 1'b0;
			end else begin
				srst_cnt_nxt = srst_cnt_r + 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// read data and drive enables, registered
	always_comb begin
		rdata_nxt = 8'h00;
		oe_nxt = 8'h00;
		if (rd_i) begin
			if (hit(addr_i, FHS_ADDR_STAT_A) && mode != FHS_MODE_AT) begin
				rdata_nxt = stat_a;
				oe_nxt = 8'hFF;
			end else if (hit(addr_i, FHS_ADDR_STAT_B) &&
				mode != FHS_MODE_AT) begin
				rdata_nxt = stat_b;
				oe_nxt = 8'hFF;
			end else if (hit(addr_i, FHS_ADDR_DOC)) begin
				rdata_nxt = doc_r;
				oe_nxt = 8'hFF;
			end else if (hit(addr_i, FHS_ADDR_TAPE)) begin
				rdata_nxt = {6'h00, tape_r};
				oe_nxt = 8'h03;
			end
		end
	end

	// hard reset only; soft reset leaves these registers alone
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			doc_r <= FHS_DOC_RST;
			tape_r <= FHS_TAPE_RST;
			srst_hold_r <= 1'b0;
			srst_cnt_r <= '0;
			rdata_r <= 8'h00;
			oe_r <= 8'h00;
		end else begin
			doc_r <= doc_nxt;
			tape_r <= tape_nxt;
			srst_hold_r <= srst_hold_nxt;
			srst_cnt_r <= srst_cnt_nxt;
			rdata_r <= rdata_nxt;
			oe_r <= oe_nxt;
		end
	end

	assign data_o = rdata_r;
	assign data_oe_o = oe_r;
endmodule

//--- bench/fhs_top_monitor.sv
// Purpose: port-level checks of the floppy host register bank
// Assumes: one clock domain, reset active low
// Notes: sees only the ports of fhs_top
`timescale 1ns/1ps
module fhs_monitor
	import fhs_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_b_i,
	input wire logic [1:0] mode_i,
	input wire logic [9:0] addr_i,
	input wire logic rd_i,
	input wire logic wr_i,
	input wire logic [7:0] data_i,
	input wire logic [7:0] data_oe_o,
	input wire logic dma_req_oe_o,
	input wire logic floppy_irq_oe_o,
	input wire logic dma_ack_n_o,
	input wire logic term_count_o,
	input wire logic soft_reset_n_o,
	input wire logic [1:0] tape_drive_o,
	input wire logic drive_sel_0_n_o,
	input wire logic drive_sel_1_n_o,
	input wire logic motor_on_0_n_o,
	input wire logic motor_on_1_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	////////////////////////////////////////////////////////////////////////
	// a host read at one address, held for one edge
	sequence s_rd(a);
		rd_i && addr_i == a;
	endsequence
	// lone read: data stands exactly one cycle
	property p_doc_rd;
		s_rd(FHS_ADDR_DOC) ##1 !rd_i |-> data_oe_o == 8'hFF ##1
			data_oe_o == 8'h00;
	endproperty
	a_doc_rd: assert property (p_doc_rd) else $error("doc read");
	property p_tape_rd;
		s_rd(FHS_ADDR_TAPE) |=> data_oe_o == 8'h03;
	endproperty
	a_tape_rd: assert property (p_tape_rd) else $error("tape oe");
	property p_at_float;
		rd_i && mode_i == FHS_MODE_AT && addr_i[9:1] == 9'h1F8 |=>
			data_oe_o == 8'h00;
	endproperty
	a_at_float: assert property (p_at_float) else $error("float");
	property p_enh_pins;
		mode_i == FHS_MODE_ENH |-> dma_req_oe_o && floppy_irq_oe_o;
	endproperty
	a_enh_pins: assert property (p_enh_pins) else $error("pins");
	property p_gate;
		!dma_req_oe_o |-> !term_count_o && dma_ack_n_o && !floppy_irq_oe_o;
	endproperty
	a_gate: assert property (p_gate) else $error("dma gate");
	// a select never shows without its motor, nor both at once
	property p_sel0;
		!drive_sel_0_n_o |-> !motor_on_0_n_o && drive_sel_1_n_o;
	endproperty
	a_sel0: assert property (p_sel0) else $error("select 0");
	property p_sel1;
		!drive_sel_1_n_o |-> !motor_on_1_n_o;
	endproperty
	a_sel1: assert property (p_sel1) else $error("select 1");
	property p_motor;
		wr_i && addr_i == FHS_ADDR_DOC |=>
			motor_on_0_n_o == !$past(data_i[4]) &&
			motor_on_1_n_o == !$past(data_i[5]);
	endproperty
	a_motor: assert property (p_motor) else $error("motor");
	property p_srst;
		wr_i && addr_i == FHS_ADDR_DOC && !data_i[2] |-> ##[1:2]
			!soft_reset_n_o;
	endproperty
	a_srst: assert property (p_srst) else $error("soft reset");
	property p_tape;
		wr_i && addr_i == FHS_ADDR_TAPE |=>
			tape_drive_o == $past(data_i[1:0]);
	endproperty
	a_tape: assert property (p_tape) else $error("tape");
endmodule
bind fhs_top fhs_monitor u_mon (.clk_i, .rst_b_i, .mode_i, .addr_i, .rd_i,
	.wr_i, .data_i, .data_oe_o, .dma_req_oe_o, .floppy_irq_oe_o,
	.dma_ack_n_o, .term_count_o, .soft_reset_n_o, .tape_drive_o,
	.drive_sel_0_n_o, .drive_sel_1_n_o, .motor_on_0_n_o, .motor_on_1_n_o);

//--- bench/fhs_drive_model.sv
// Purpose: drive-side lines seen by the register bank
// Assumes: lines idle low between pulses
// Notes: index 0 step, 1 write gate, 2 read data, 3 write data
`timescale 1ns/1ps
module fhs_drive_model (
	input wire logic clk_i,
	output logic step_o,
	output logic write_gate_o,
	output logic read_data_o,
	output logic write_data_o
);
	logic [3:0] line_r = 4'h0;
	assign {write_data_o, read_data_o, write_gate_o, step_o} = line_r;
	// three cycles high then three low, so each edge is seen once
	task automatic pulse(input int k);
		@(negedge clk_i);
		line_r[k] = 1'b1;
		repeat (3) @(negedge clk_i);
		line_r[k] = 1'b0;
		repeat (3) @(negedge clk_i);
	endtask
endmodule

//--- bench/tb_floppy_host_status_control.sv
// Purpose: self-checking bench of the floppy host register bank
// Assumes: inputs change on the falling edge
// Notes: reset values first, then output-control rows, then reset and mode cases
`timescale 1ns/1ps
module tb_floppy_host_status_control
	import fhs_pkg::*;
;
	logic clk_i, rst_b_i, rd_i, wr_i, step_i, write_gate_i;
	logic read_data_i, write_data_i, head_dir_in_i, head_side_select_i;
	logic dma_req_core_i, floppy_irq_core_i, dma_ack_n_i, term_count_i;
	logic write_protect_i, index_pulse_i, track_zero_i;
	logic dma_req_o, dma_req_oe_o, floppy_irq_o, floppy_irq_oe_o;
	logic dma_ack_n_o, term_count_o, soft_reset_n_o;
	logic drive_sel_0_n_o, drive_sel_1_n_o, motor_on_0_n_o, motor_on_1_n_o;
	logic [1:0] mode_i, tape_drive_o;
	logic [9:0] addr_i;
	logic [7:0] data_i, data_o, data_oe_o;
	int error_cnt = 0;
	int check_count = 0;
	int n;
	// write value, read value, sel0_n sel1_n mot0_n mot1_n
	logic [19:0] rows [5] = '{20'h1C1C5, 20'h2D2DA, 20'h0C0CF, 20'hFE3EC,
		20'h1D1DD};
	fhs_top DUT (.clk_i, .rst_b_i, .mode_i, .addr_i, .rd_i, .wr_i, .data_i,
		.data_o, .data_oe_o, .head_dir_in_i, .head_side_select_i,
		.write_protect_i, .index_pulse_i, .track_zero_i,
		.step_i, .write_gate_i, .read_data_i, .write_data_i, .dma_req_core_i,
		.floppy_irq_core_i, .dma_ack_n_i, .term_count_i, .dma_req_o,
		.dma_req_oe_o, .floppy_irq_o, .floppy_irq_oe_o, .dma_ack_n_o,
		.term_count_o, .soft_reset_n_o, .tape_drive_o, .drive_sel_0_n_o,
		.drive_sel_1_n_o, .motor_on_0_n_o, .motor_on_1_n_o);
	fhs_drive_model u_drv (.clk_i, .step_o(step_i),
		.write_gate_o(write_gate_i), .read_data_o(read_data_i),
		.write_data_o(write_data_i));
	////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [7:0] g, e);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("wrong value at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(negedge clk_i);
		addr_i = a;
		data_i = d;
		wr_i = 1'b1;
		@(negedge clk_i);
		wr_i = 1'b0;
	endtask
	// only bits enabled in m are compared, floating ones are ignored
	task automatic rdc(input logic [9:0] a, input logic [7:0] d, m);
		@(negedge clk_i);
		addr_i = a;
		rd_i = 1'b1;
		@(negedge clk_i);
		rd_i = 1'b0;
		chk(data_oe_o, m);
		chk(data_o & m, d & m);
	endtask
	// soft reset release is stretched, so wait with a bound
	task automatic wait_srst();
		n = 0;
		while (soft_reset_n_o !== 1'b1 && n < 64) begin
			@(negedge clk_i);
			n++;
		end
		chk(8'(soft_reset_n_o), 8'h01);
		if (n == 64) begin
			end_of_test();
		end
	endtask
	task automatic end_of_test();
		if (error_cnt == 0 && check_count > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		clk_i = 1'b0;
		forever #2 clk_i = ~clk_i;
	end
	initial begin
		#100000;
		error_cnt++;
		end_of_test();
	end
	initial begin
		{rst_b_i, rd_i, wr_i, addr_i, data_i, term_count_i} = '0;
		{head_dir_in_i, head_side_select_i, dma_req_core_i} = '0;
		{write_protect_i, index_pulse_i, track_zero_i} = '0;
		floppy_irq_core_i = 1'b0;
		dma_ack_n_i = 1'b1;
		mode_i = FHS_MODE_ENH;
		repeat (16) @(negedge clk_i);
		// pins stay enabled while the hard reset is still applied
		chk(8'({dma_req_oe_o, floppy_irq_oe_o, soft_reset_n_o}), 8'h06);
		rst_b_i = 1'b1;
		rdc(FHS_ADDR_DOC, 8'h00, 8'hFF);
		chk(8'(soft_reset_n_o), 8'h00);
		rdc(FHS_ADDR_STAT_B, 8'hC0, 8'hFF);
		for (int i = 0; i < 5; i++) begin
			wr(FHS_ADDR_DOC, rows[i][19:12]);
			rdc(FHS_ADDR_DOC, rows[i][11:4], 8'hFF);
			chk(8'({drive_sel_0_n_o, drive_sel_1_n_o, motor_on_0_n_o,
				motor_on_1_n_o}), 8'(rows[i][3:0]));
		end
		wr(FHS_ADDR_TAPE, 8'hFF);
		chk(8'(tape_drive_o), 8'h03);
		wr(FHS_ADDR_DOC, 8'h2D);
		wait_srst();
		wr(FHS_ADDR_DOC, 8'h29);
		@(negedge clk_i);
		chk(8'(soft_reset_n_o), 8'h00);
		rdc(FHS_ADDR_DOC, 8'h29, 8'hFF);
		rdc(FHS_ADDR_TAPE, 8'h03, 8'h03);
		rdc(FHS_ADDR_STAT_B, 8'hE2, 8'hFF);
		wr(FHS_ADDR_DOC, 8'h2D);
		wait_srst();
		u_drv.pulse(2);
		rdc(FHS_ADDR_STAT_B, 8'hEA, 8'hFF);
		u_drv.pulse(3);
		rdc(FHS_ADDR_STAT_B, 8'hFA, 8'hFF);
		// alternate layouts: stickies set by the pulses, cleared by a read
		mode_i = FHS_MODE_ALT;
		wr(FHS_ADDR_DOC, 8'h1C);
		rdc(FHS_ADDR_DIN, 8'h00, 8'h00);
		rdc(FHS_ADDR_STAT_B, 8'hC3, 8'hFF);
		u_drv.pulse(1);
		u_drv.pulse(2);
		u_drv.pulse(3);
		rdc(FHS_ADDR_STAT_B, 8'hDF, 8'hFF);
		{head_dir_in_i, head_side_select_i} = 2'h3;
		{dma_req_core_i, floppy_irq_core_i} = 2'h3;
		{write_protect_i, index_pulse_i, track_zero_i} = 3'h7;
		u_drv.pulse(0);
		rdc(FHS_ADDR_STAT_A, 8'hF6, 8'hFF);
		chk(8'({dma_req_o, floppy_irq_o}), 8'h03);
		{head_dir_in_i, head_side_select_i} = 2'h0;
		{dma_req_core_i, floppy_irq_core_i} = 2'h0;
		{write_protect_i, index_pulse_i, track_zero_i} = 3'h0;
		rdc(FHS_ADDR_DIN, 8'h00, 8'h00);
		rdc(FHS_ADDR_STAT_A, 8'h09, 8'hFF);
		rdc(FHS_ADDR_STAT_B, 8'hC3, 8'hFF);
		// a back-to-back soft reset pulse drops the step sticky
		u_drv.pulse(0);
		wr(FHS_ADDR_DOC, 8'h18);
		wr(FHS_ADDR_DOC, 8'h1C);
		chk(8'(soft_reset_n_o), 8'h00);
		rdc(FHS_ADDR_STAT_A, 8'h09, 8'hFF);
		chk(8'(dma_req_oe_o), 8'h01);
		term_count_i = 1'b1;
		dma_ack_n_i = 1'b0;
		@(negedge clk_i);
		chk(8'({term_count_o, dma_ack_n_o}), 8'h02);
		wr(FHS_ADDR_DOC, 8'h14);
		chk(8'({dma_req_oe_o, floppy_irq_oe_o, term_count_o}), 8'h00);
		chk(8'(dma_ack_n_o), 8'h01);
		mode_i = FHS_MODE_ENH;
		@(negedge clk_i);
		chk(8'({dma_req_oe_o, floppy_irq_oe_o}), 8'h03);
		chk(8'({term_count_o, dma_ack_n_o}), 8'h02);
		mode_i = FHS_MODE_AT;
		rdc(FHS_ADDR_STAT_A, 8'h00, 8'h00);
		rdc(FHS_ADDR_STAT_B, 8'h00, 8'h00);
		// spare mode code falls back to the alternate layouts
		mode_i = 2'h3;
		rdc(FHS_ADDR_STAT_B, 8'hC3, 8'hFF);
		// hard reset in mid-run clears what a soft reset keeps
		mode_i = FHS_MODE_ENH;
		rst_b_i = 1'b0;
		repeat (2) @(negedge clk_i);
		rst_b_i = 1'b1;
		rdc(FHS_ADDR_DOC, 8'h00, 8'hFF);
		rdc(FHS_ADDR_STAT_B, 8'hC0, 8'hFF);
		rdc(FHS_ADDR_TAPE, 8'h00, 8'h03);
		end_of_test();
	end
endmodule
